/* File: core/scp_regs.svh */
/*
  Offsets, field positions, reset values and counts of the serial control port.
  Assumes inclusion by bare name from the port module.
*/
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// ==========================================================================
// Register offsets
`define CPC_OFFSET 16'h005E
`define AIC_OFFSET 16'h00FF

// ==========================================================================
// Field positions
`define CPC_CONTRD_BIT 6
`define CPC_FOURWIRE_BIT 5
`define CPC_OPENDRAIN_BIT 4
`define AIC_AUTOINC_BIT 0

// ==========================================================================
// Reset values
`define CPC_RESET 16'h0000
`define AIC_RESET 16'h0001

// ==========================================================================
// Shared pin six and serial word counts
`define PIN6_FN_CS 5'h00
`define PIN6_DIR_CS 1'b1
`define SPI_HDR_LAST 6'd15
`define SPI_WORD_LAST 6'd31
`define SPI_WORD_BITS 6'd32
`define SPI_DATA_START 6'd16
`define I2C_BYTE_BITS 4'd8

`endif

/* File: core/scp_pkg.sv */
/*
  Types shared by the serial control port modules.
  Assumes scp_regs.svh is on the include path.
*/
package scp_pkg;

  // ========================================================================
  // Latched port configuration
  typedef struct packed {
    logic contrd;
    logic four_wire;
    logic open_drain;
  } port_cfg_t;

  // ========================================================================
  // Serial control word, first bit received at the top
  typedef struct packed {
    logic rw;
    logic [14:0] addr;
    logic [15:0] data;
  } spi_word_t;

  // ========================================================================
  // Pin drive pair
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  // ========================================================================
  // Two-wire engine states
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_RX = 3'b001,
    I_ACK = 3'b011,
    I_TX = 3'b010,
    I_MACK = 3'b110
  } i2c_state_t;

  // ========================================================================
  // Where the serial readback output sits
  typedef enum logic [1:0] {
    SDO_NONE = 2'h0,
    SDO_PIN2 = 2'h1,
    SDO_PIN3 = 2'h2,
    SDO_PIN5 = 2'h3
  } serial_readback_out_pin_t;

endpackage

/* File: core/scp_sync.sv */
/*
  Two flip-flop synchroniser, one stage pair per bit.
  Assumes inputs are asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/100ps
module scp_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  // ========================================================================
  // Per-bit stages
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= async_i[g];
          stab_q <= meta_q;
        end
      end
      assign sync_o[g] = stab_q;
    end
  endgenerate
endmodule // scp_sync

/* File: core/scp_regmem.sv */
/*
  Register map storage: one write port, one always-reading port.
  Assumes the read address is stable a cycle before the data is used.
*/
`timescale 1ns/100ps
module scp_regmem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  // ========================================================================
  // Storage
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule // scp_regmem

/* File: core/serial_control_port_config.sv */
/*
  Serial control port: two-wire or SPI access to the register map.
  Assumes clk is the system clock; serial pins are asynchronous and are
  sampled, so sclk must stay below a quarter of the clk rate.
*/
// Operation
// [RULE1] Writes stored, every register read back
// [RULE2] Strap low two-wire, high SPI
// [RULE3] Pins used per mode, shared select
// [RULE4] Readback on data pin or serial-out
// [RULE5] Select only with function zero, direction one
// [RULE6] Sixteen-bit two-wire, fifteen-bit SPI addresses
// [RULE7] Host writes parameter words whole, high first
// [RULE8] Host writes parameter sets in order
// [RULE9] Map access synchronised to system clock
// [RULE10] Two-wire address auto-increment, default on
// [RULE11] Bit five picks three or four wire
// [RULE12] Continuous read walks successive addresses
// [RULE13] Three-wire readback CMOS or open drain
// [RULE14] Pin five drives low or releases; in open-drain mode the code drives the readback bit high and low while reading
// [RULE15] Pins two and three always CMOS
// [RULE16] Thirty-two bit word latched at select rise
// [RULE17] Step address after thirty-two clocks
// [RULE18] Four-wire read ignores data-in
// [RULE19] Config changes apply from next transaction
`timescale 1ns/100ps
`include "scp_regs.svh"
module serial_control_port_config #(
  parameter int MEM_AW = 8,
  parameter logic [6:0] DEVICE_ADDR = 7'h1A
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic port_protocol_select_pin,
  input wire logic serial_clock_pin,
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe,
  input wire logic chip_select_shared_pin,
  input wire logic [4:0] pin_six_function_field,
  input wire logic pin_six_direction_bit,
  input wire scp_pkg::serial_readback_out_pin_t serial_readback_out_pin_select,
  output logic general_pin_two_o,
  output logic general_pin_two_oe,
  output logic general_pin_three_o,
  output logic general_pin_three_oe,
  output logic general_pin_five_o,
  output logic general_pin_five_oe
);
  import scp_pkg::*;

  // ========================================================================
  // Pin sampling
  logic s_proto, s_sclk, s_sda, s_cs;
  logic sclk_prev_q, sda_prev_q, cs_low_prev_q;

  scp_sync #(.W(4)) u_sync ( // [RULE9]
    .clk(clk),
    .reset_n(reset_n),
    .async_i({port_protocol_select_pin, serial_clock_pin, data_pin_i, chip_select_shared_pin}),
    .sync_o({s_proto, s_sclk, s_sda, s_cs})
  );

  wire spi_sel = s_proto; // [RULE2]
  wire cs_ok = (pin_six_function_field == `PIN6_FN_CS) && (pin_six_direction_bit == `PIN6_DIR_CS); // [RULE5]
  wire cs_low = spi_sel & cs_ok & ~s_cs; // [RULE3]
  wire cs_fall = cs_low & ~cs_low_prev_q;
  wire cs_rise = ~cs_low & cs_low_prev_q;
  wire sclk_rise = s_sclk & ~sclk_prev_q;
  wire sclk_fall = ~s_sclk & sclk_prev_q;
  wire i2c_start = ~spi_sel & s_sclk & sclk_prev_q & sda_prev_q & ~s_sda;
  wire i2c_stop = ~spi_sel & s_sclk & sclk_prev_q & ~sda_prev_q & s_sda;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b0;
      sda_prev_q <= 1'b1;
      cs_low_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= s_sclk;
      sda_prev_q <= s_sda;
      cs_low_prev_q <= cs_low;
    end
  end

  // ========================================================================
  // Configuration registers and map
  logic [15:0] cpc_q, aic_q, addr_q, mem_rdata;
  logic [15:0] wr_addr, wr_data;
  logic wr_en;
  port_cfg_t cfg_now, act_cfg_q;
  wire autoinc = aic_q[`AIC_AUTOINC_BIT];
  assign cfg_now = '{contrd: cpc_q[`CPC_CONTRD_BIT], four_wire: cpc_q[`CPC_FOURWIRE_BIT],
                     open_drain: cpc_q[`CPC_OPENDRAIN_BIT]};
  // Config words live in flops so the port logic can see them without a read
  wire [15:0] read_word = (addr_q == `CPC_OFFSET) ? cpc_q :
                          (addr_q == `AIC_OFFSET) ? aic_q : mem_rdata; // [RULE1]

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cpc_q <= `CPC_RESET; // [RULE11]
      aic_q <= `AIC_RESET; // [RULE10]
    end else if (wr_en) begin
      if (wr_addr == `CPC_OFFSET) cpc_q <= wr_data; // [RULE1]
      if (wr_addr == `AIC_OFFSET) aic_q <= wr_data;
    end
  end

  scp_regmem #(.AW(MEM_AW), .DW(16)) u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .we(wr_en),
    .waddr(wr_addr[MEM_AW-1:0]),
    .wdata(wr_data),
    .raddr(addr_q[MEM_AW-1:0]),
    .rdata_q(mem_rdata)
  );

  // ========================================================================
  // SPI engine
  logic [31:0] shift_q;
  logic [5:0] bits_q;
  logic reading_q, shift_pend_q;
  logic [1:0] load_pend_q;
  logic [15:0] out_q;
  spi_word_t word;
  assign word = shift_q;

  wire spi_clk_rise = cs_low & sclk_rise;
  wire spi_hdr_done = spi_clk_rise & ~reading_q & (bits_q == `SPI_HDR_LAST) & shift_q[14];
  wire spi_next = spi_clk_rise & reading_q & (bits_q == `SPI_WORD_LAST) & act_cfg_q.contrd; // [RULE17]
  wire spi_wr = cs_rise & ~reading_q & (bits_q == `SPI_WORD_BITS) & ~word.rw; // [RULE16]

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      act_cfg_q <= '0;
    end else if (cs_fall) begin
      act_cfg_q <= cfg_now; // [RULE19]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_q <= '0;
      bits_q <= '0;
      reading_q <= 1'b0;
    end else if (cs_fall) begin
      bits_q <= '0;
      reading_q <= 1'b0;
    end else if (cs_rise) begin
      reading_q <= 1'b0;
    end else if (spi_clk_rise) begin
      if (!reading_q) begin
        shift_q <= {shift_q[30:0], s_sda}; // [RULE18]
      end
      if (spi_next) begin
        bits_q <= `SPI_DATA_START; // [RULE12]
      end else if (bits_q != `SPI_WORD_BITS) begin
        bits_q <= bits_q + 6'd1;
      end
      if (spi_hdr_done) reading_q <= 1'b1;
    end
  end

  // Two cycles of wait: one for the address flop, one for the map read flop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      load_pend_q <= '0;
      shift_pend_q <= 1'b0;
      out_q <= '0;
    end else begin
      load_pend_q <= {load_pend_q[0], spi_hdr_done | spi_next};
      if (load_pend_q[1]) begin
        out_q <= read_word; // [RULE17]
        shift_pend_q <= 1'b0;
      end else if (spi_clk_rise && reading_q && !spi_next) begin
        shift_pend_q <= 1'b1;
      end else if (sclk_fall && shift_pend_q) begin
        out_q <= {out_q[14:0], 1'b0};
        shift_pend_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Two-wire engine
  i2c_state_t i_state_q;
  logic [3:0] i_bit_q;
  logic [2:0] i_byte_q;
  logic [7:0] i_rx_q, i_hi_q, i_tx_q;
  logic i_rd_q, i_half_q;

  wire i_on = ~spi_sel;
  wire i_rise = i_on & sclk_rise;
  wire i_fall = i_on & sclk_fall;
  wire i_rx_done = i_fall & (i_state_q == I_RX) & (i_bit_q == `I2C_BYTE_BITS);
  wire i_id_match = (i_rx_q[7:1] == DEVICE_ADDR);
  wire i2c_wr = i_rx_done & (i_byte_q == 3'd4);
  wire i_mack_ok = i_rise & (i_state_q == I_MACK) & ~s_sda;
  wire i2c_inc = autoinc & (i2c_wr | (i_mack_ok & i_half_q)); // [RULE10]
  wire [7:0] i_tx_next = i_half_q ? read_word[7:0] : read_word[15:8];

  always_ff @(posedge clk) begin
    if (!reset_n || spi_sel) begin
      i_state_q <= I_IDLE; // [RULE2]
      i_bit_q <= '0;
      i_byte_q <= '0;
      i_rx_q <= '0;
      i_hi_q <= '0;
      i_tx_q <= '0;
      i_rd_q <= 1'b0;
      i_half_q <= 1'b0;
    end else if (i2c_start) begin
      i_state_q <= I_RX;
      i_bit_q <= '0;
      i_byte_q <= '0;
      i_half_q <= 1'b0;
    end else if (i2c_stop) begin
      i_state_q <= I_IDLE;
    end else begin
      case (i_state_q)
        I_RX: begin
          if (i_rise) begin
            i_rx_q <= {i_rx_q[6:0], s_sda};
            i_bit_q <= i_bit_q + 4'd1;
          end else if (i_rx_done) begin
            i_bit_q <= '0;
            i_state_q <= I_ACK;
            i_byte_q <= (i_byte_q == 3'd4) ? 3'd3 : i_byte_q + 3'd1;
            if (i_byte_q == 3'd0) begin
              i_rd_q <= i_rx_q[0];
              if (!i_id_match) i_state_q <= I_IDLE;
            end
            if (i_byte_q == 3'd3) i_hi_q <= i_rx_q;
          end
        end
        I_ACK: begin
          if (i_fall) begin
            i_state_q <= i_rd_q ? I_TX : I_RX;
            i_tx_q <= i_tx_next;
          end
        end
        I_TX: begin
          if (i_rise) begin
            i_bit_q <= i_bit_q + 4'd1;
          end else if (i_fall) begin
            if (i_bit_q == `I2C_BYTE_BITS) begin
              i_state_q <= I_MACK;
              i_bit_q <= '0;
            end else begin
              i_tx_q <= {i_tx_q[6:0], 1'b0};
            end
          end
        end
        I_MACK: begin
          if (i_rise) begin
            if (s_sda) i_state_q <= I_IDLE;
            else i_half_q <= ~i_half_q;
          end else if (i_fall) begin
            i_state_q <= I_TX;
            i_tx_q <= i_tx_next;
          end
        end
        default: i_state_q <= I_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Shared access address and write port
  assign wr_en = spi_wr | i2c_wr;
  assign wr_addr = spi_sel ? {1'b0, word.addr} : addr_q; // [RULE6]
  assign wr_data = spi_sel ? word.data : {i_hi_q, i_rx_q};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_q <= '0;
    end else if (spi_hdr_done) begin
      addr_q <= {1'b0, shift_q[13:0], s_sda}; // [RULE6]
    end else if (spi_next) begin
      addr_q <= {1'b0, addr_q[14:0] + 15'd1}; // [RULE12]
    end else if (i_rx_done && i_byte_q == 3'd1) begin
      addr_q <= {i_rx_q, addr_q[7:0]};
    end else if (i_rx_done && i_byte_q == 3'd2) begin
      addr_q <= {addr_q[15:8], i_rx_q};
    end else if (i2c_inc) begin
      addr_q <= addr_q + 16'd1;
    end
  end

  // ========================================================================
  // Pin drivers
  wire spi_bit = reading_q & out_q[15];
  wire spi3 = spi_sel & ~act_cfg_q.four_wire;
  wire spi4 = spi_sel & act_cfg_q.four_wire;
  pin_drive_t dpin_d, p2_d, p3_d, p5_d, dpin_q, p2_q, p3_q, p5_q;

  // Open drain on the data pin only ever pulls low, so a one is shown by letting go; pin five drives both levels
  assign dpin_d = (i_state_q == I_ACK) ? '{o: 1'b0, oe: 1'b1} :
                  (i_state_q == I_TX) ? '{o: 1'b0, oe: ~i_tx_q[7]} :
                  (spi3 && reading_q) ? '{o: spi_bit,
                                          oe: ~act_cfg_q.open_drain | ~spi_bit} :
                  '{o: 1'b0, oe: 1'b0}; // [RULE4] [RULE13]
  assign p5_d = !(spi4 && serial_readback_out_pin_select == SDO_PIN5) ? '{o: 1'b0, oe: 1'b0} :
                act_cfg_q.open_drain ? '{o: spi_bit, oe: reading_q} :
                '{o: spi_bit, oe: 1'b1}; // [RULE14]
  assign p2_d = '{o: spi_bit, oe: spi4 && serial_readback_out_pin_select == SDO_PIN2}; // [RULE15]
  assign p3_d = '{o: spi_bit, oe: spi4 && serial_readback_out_pin_select == SDO_PIN3}; // [RULE15]

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dpin_q <= '0;
      p2_q <= '0;
      p3_q <= '0;
      p5_q <= '0;
    end else begin
      dpin_q <= dpin_d;
      p2_q <= p2_d;
      p3_q <= p3_d;
      p5_q <= p5_d;
    end
  end

  assign data_pin_o = dpin_q.o;
  assign data_pin_oe = dpin_q.oe;
  assign general_pin_two_o = p2_q.o;
  assign general_pin_two_oe = p2_q.oe;
  assign general_pin_three_o = p3_q.o;
  assign general_pin_three_oe = p3_q.oe;
  assign general_pin_five_o = p5_q.o;
  assign general_pin_five_oe = p5_q.oe;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cfg_store;
    wr_en && wr_addr == `CPC_OFFSET |=> cpc_q == $past(wr_data);
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("config write lost"); // [RULE1]

  property p_i2c_off_in_spi;
    spi_sel ##1 spi_sel |-> i_state_q == I_IDLE;
  endproperty
  a_i2c_off_in_spi: assert property (p_i2c_off_in_spi) else $error("two-wire busy in SPI"); // [RULE2]

  property p_no_gpio_i2c;
    !spi_sel ##1 !spi_sel |-> !general_pin_two_oe && !general_pin_three_oe && !general_pin_five_oe;
  endproperty
  a_no_gpio_i2c: assert property (p_no_gpio_i2c) else $error("GPIO driven in two-wire"); // [RULE3]

  property p_four_wire_quiet;
    spi_sel && act_cfg_q.four_wire |=> !data_pin_oe;
  endproperty
  a_four_wire_quiet: assert property (p_four_wire_quiet) else $error("data pin driven in 4-wire"); // [RULE4]

  property p_cs_gate;
    !cs_low && !cs_low_prev_q |=> $stable(bits_q) && $stable(shift_q);
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("shift without select"); // [RULE5]

  property p_spi_addr15;
    spi_sel && reading_q |-> !addr_q[15];
  endproperty
  a_spi_addr15: assert property (p_spi_addr15) else $error("SPI address above 15 bits"); // [RULE6]

  property p_autoinc;
    i2c_wr && autoinc |=> addr_q == $past(addr_q) + 16'd1;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("no auto-increment"); // [RULE10]

  property p_cfg_latch;
    cs_fall |=> act_cfg_q.four_wire == $past(cpc_q[`CPC_FOURWIRE_BIT]) && act_cfg_q.contrd == $past(cpc_q[`CPC_CONTRD_BIT]);
  endproperty
  a_cfg_latch: assert property (p_cfg_latch) else $error("config not latched"); // [RULE11]

  property p_cfg_hold;
    !cs_fall |=> $stable(act_cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed mid-transfer"); // [RULE19]

  property p_contrd_step;
    spi_next |=> bits_q == `SPI_DATA_START && addr_q[14:0] == $past(addr_q[14:0]) + 15'd1 ##2 out_q == $past(read_word);
  endproperty
  a_contrd_step: assert property (p_contrd_step) else $error("continuous read step wrong"); // [RULE12] [RULE17]

  property p_open_drain;
    spi3 && act_cfg_q.open_drain |=> !(data_pin_oe && data_pin_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // [RULE13]

  property p_pin5_cmos;
    spi4 && !act_cfg_q.open_drain && serial_readback_out_pin_select == SDO_PIN5 |=> general_pin_five_oe && (general_pin_five_o == $past(spi_bit));
  endproperty
  a_pin5_cmos: assert property (p_pin5_cmos) else $error("pin five not CMOS"); // [RULE14]

  property p_pin2_cmos;
    spi4 && serial_readback_out_pin_select == SDO_PIN2 |=> general_pin_two_oe;
  endproperty
  a_pin2_cmos: assert property (p_pin2_cmos) else $error("pin two not CMOS"); // [RULE15]

  property p_word_latch;
    spi_sel && cs_rise && !reading_q && bits_q == `SPI_WORD_BITS && !shift_q[31] |-> wr_en && wr_addr == {1'b0, shift_q[30:16]};
  endproperty
  a_word_latch: assert property (p_word_latch) else $error("SPI word not written"); // [RULE16]

  property p_ignore_din;
    reading_q && !cs_fall |=> $stable(shift_q);
  endproperty
  a_ignore_din: assert property (p_ignore_din) else $error("data-in sampled in read"); // [RULE18]

  c_spi_write: cover property (spi_wr);
  c_continuous_read_enable: cover property (spi_next);
  c_i2c_write: cover property (i2c_wr);
  c_i2c_read: cover property (i_mack_ok);
endmodule // serial_control_port_config

/* File: testbench/spi_host_model.sv */
/*
  Host side of the serial control port: an SPI master that frames words.
  Assumes the bench resolves the data wire and returns the readback line.
*/
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  input wire logic miso,
  input wire logic jam,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  output logic mosi_oe
);
  // ========================================================================
  // Idle bus: clock stands low, select high, wire released
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    mosi_oe = 1'b0;
  end

  // ========================================================================
  // Whole words only, top bit first; parameter words sent whole, in order
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] r);
    int i;
    r = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    // Bits are sampled at the end of the high phase, because readback moves
    // about four clocks after each fall and would race a sample taken at the rise.
    for (i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      if (i < n - 1) r[i+1] = miso;
      sclk <= 1'b0;
      // Released during read data unless junk is wanted on data-in
      mosi_oe <= !(w[n-1] && i < n - 16) || jam;
      mosi <= (w[n-1] && i < n - 16) ? i[0] : w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    r[0] = miso;
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    mosi_oe <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
endmodule // spi_host_model

/* File: testbench/tb_serial_control_port_config.sv */
/*
  Self-checking bench for the serial control port, SPI side.
  Assumes the host model frames words and the data wire has a pull-up.
*/
`timescale 1ns/100ps
module tb_serial_control_port_config;
  import scp_pkg::*;
  logic clk, reset_n, strap, jam, dir6, drive_bad;
  logic [4:0] fn6;
  logic [1:0] mon;
  serial_readback_out_pin_t sdsel;
  logic sclk, cs_n, mosi, mosi_oe, data_wire, miso;
  logic d_o, d_oe, p2_o, p2_oe, p3_o, p3_oe, p5_o, p5_oe;
  logic [47:0] rd;
  int err_total, check_count, k;

  // ========================================================================
  // Wire resolution: pull-up on the data wire and pin five; pins two and three are read as driven
  assign data_wire = d_oe ? d_o : (mosi_oe ? mosi : 1'b1);
  assign miso = (sdsel == SDO_PIN2) ? p2_o : (sdsel == SDO_PIN3) ? p3_o :
                (sdsel == SDO_PIN5) ? (p5_oe ? p5_o : 1'b1) : data_wire;

  spi_host_model host (.clk(clk), .miso(miso), .jam(jam), .sclk(sclk), .cs_n(cs_n),
                       .mosi(mosi), .mosi_oe(mosi_oe));

  serial_control_port_config dut (
    .clk(clk), .reset_n(reset_n), .port_protocol_select_pin(strap),
    .serial_clock_pin(sclk), .data_pin_i(data_wire), .data_pin_o(d_o),
    .data_pin_oe(d_oe), .chip_select_shared_pin(cs_n), .pin_six_function_field(fn6),
    .pin_six_direction_bit(dir6), .serial_readback_out_pin_select(sdsel),
    .general_pin_two_o(p2_o), .general_pin_two_oe(p2_oe),
    .general_pin_three_o(p3_o), .general_pin_three_oe(p3_oe),
    .general_pin_five_o(p5_o), .general_pin_five_oe(p5_oe));

  // ========================================================================
  // Sticky watch: open drain never drives high, four-wire never drives data
  always @(posedge clk) begin
    if ((mon == 2'd1 && d_oe && d_o) || (mon == 2'd2 && d_oe)) begin
      drive_bad <= 1'b1;
    end
  end

  // ========================================================================
  // Compare, access and closing tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    host.xfer({16'h0000, 1'b0, a, d}, 32, rd);
  endtask

  task automatic rdchk(input string what, input logic [14:0] a, input logic [15:0] exp);
    host.xfer({16'h0000, 1'b1, a, 16'h0000}, 32, rd);
    check(what, rd[15:0], exp);
  endtask

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // ========================================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    strap = 1'b1;
    jam = 1'b0;
    fn6 = 5'h00;
    dir6 = 1'b1;
    sdsel = SDO_NONE;
    mon = 2'd0;
    drive_bad = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    check("oe in reset", {12'h000, d_oe, p2_oe, p3_oe, p5_oe}, 16'h0000);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk("cfg reset", 15'h005E, 16'h0000);
    rdchk("autoinc reset", 15'h00FF, 16'h0001);
    wr(15'h0010, 16'hA5C3);
    wr(15'h0011, 16'h3C5A);
    rdchk("map word", 15'h0010, 16'hA5C3);
    // Open drain: ones on the wire come from the pull-up only
    wr(15'h005E, 16'h0010);
    mon <= 2'd1;
    rdchk("open drain", 15'h0011, 16'h3C5A);
    wr(15'h005E, 16'h0020);
    sdsel <= SDO_PIN5;
    jam <= 1'b1;
    mon <= 2'd2;
    rdchk("four wire", 15'h0010, 16'hA5C3);
    check("pin5 idle", {14'h0000, p5_oe, p5_o}, 16'h0002);
    wr(15'h005E, 16'h0030);
    rdchk("wired or", 15'h0011, 16'h3C5A);
    check("pin5 released", {15'h0000, p5_oe}, 16'h0000);
    for (k = 1; k < 3; k++) begin
      sdsel <= serial_readback_out_pin_t'(k);
      rdchk("pin2 or 3", 15'h0010, 16'hA5C3);
      check("pin2 or 3 idle", (k == 1) ? {14'h0000, p2_oe, p2_o} : {14'h0000, p3_oe, p3_o},
            16'h0002);
    end
    check("data pin drive", {15'h0000, drive_bad}, 16'h0000);
    // Continuous read: second word comes from the next address
    wr(15'h005E, 16'h0040);
    sdsel <= SDO_NONE;
    jam <= 1'b0;
    mon <= 2'd0;
    host.xfer({1'b1, 15'h0010, 32'h00000000}, 48, rd);
    check("contrd first", rd[31:16], 16'hA5C3);
    check("contrd next", rd[15:0], 16'h3C5A);
    wr(15'h005E, 16'h0000);
    // Writes with pin six not a select, or with the two-wire strap, are ignored
    fn6 <= 5'h01;
    wr(15'h0010, 16'hFFFF);
    fn6 <= 5'h00;
    dir6 <= 1'b0;
    wr(15'h0010, 16'h0000);
    dir6 <= 1'b1;
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    wr(15'h0010, 16'h1111);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("select gated", 15'h0010, 16'hA5C3);
    wrap_up();
  end
endmodule // tb_serial_control_port_config
